// ---- src/bem_pkg.sv ----
// package: register map, field layout and types of the channel event and receive logic
package bem_pkg;

    // register byte offsets
    localparam logic [7:0] BEM_OFS_EVENT = 8'h00;
    localparam logic [7:0] BEM_OFS_ENABLE = 8'h04;
    localparam logic [7:0] BEM_OFS_MODE = 8'h08;
    localparam logic [7:0] BEM_OFS_CMD = 8'h0c;
    localparam logic [7:0] BEM_OFS_STATUS = 8'h10;
    localparam logic [7:0] BEM_OFS_CHARS = 8'h14;
    localparam logic [2:0] BEM_TBL_PAGE = 3'h1; // table entries at 0x20 + 4*index

    // control character table geometry
    localparam int BEM_TBL_N = 8;
    localparam int BEM_TBL_IW = 3;

    // event bit positions
    localparam int EV_CTS = 7;
    localparam int EV_CD = 6;
    localparam int EV_RSVD = 5;
    localparam int EV_TXE = 4;
    localparam int EV_RCH = 3;
    localparam int EV_NOBUF = 2;
    localparam int EV_TX = 1;
    localparam int EV_RX = 0;
    localparam logic [7:0] EV_WMASK = 8'hdf; // reserved bit 5 never stored

    // mode, command and status field positions
    localparam int MODE_TRANSP = 0;
    localparam int MODE_CHKINC = 1;
    localparam int CMD_CLRCHK = 0;
    localparam int CMD_RESYNC = 1;
    localparam int ST_CTS = 0;
    localparam int ST_CD = 1;
    localparam int ST_HUNTING = 2;
    localparam int ST_DLEPEND = 3;
    localparam int ST_HALTED = 4;
    localparam int ST_ACC_LSB = 8;

    // reset values
    localparam logic [7:0] BEM_RST_EVENT = 8'h00;
    localparam logic [7:0] BEM_RST_ENABLE = 8'h00;
    localparam logic [1:0] BEM_RST_MODE = 2'h1 << MODE_CHKINC;
    localparam logic [7:0] BEM_RST_SYNC = 8'h32;
    localparam logic [7:0] BEM_RST_DLE = 8'h10;
    localparam logic [7:0] BEM_RST_ACC = 8'h00;
    localparam logic [1:0] BEM_CHECK_BYTES = 2'h2;

    // ahb-lite codes
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // one entry of the receive control character table
    typedef struct packed {
        logic hunt;   // enter hunt after the block closes
        logic check;  // check sequence follows before close
        logic last;   // table end, no entries beyond
        logic [7:0] ch;
    } bem_entry_s;

    localparam bem_entry_s BEM_RST_ENTRY = '{hunt: 1'b0, check: 1'b0, last: 1'b1, ch: 8'h00};

    // receive buffer write strobe toward the buffer logic
    typedef struct packed {
        logic wr;
        logic ctrl;   // character matched a table entry, except unescaped characters in transparent mode and check bytes
        logic chk;    // character is part of the check sequence
        logic [7:0] data;
    } bem_rxwr_s;

    // receiver states, one-hot
    typedef enum logic [2:0] {
        RX_HUNT = 3'b001,
        RX_RECV = 3'b010,
        RX_CHECK = 3'b100
    } bem_rx_e;

endpackage

// ---- src/bem_channel.sv ----
// module: channel event flags, event enable mask, interrupt request and receive recognition
`timescale 1ns/1ps

module bem_channel
    import bem_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // modem lines
    input wire logic cts_i,
    input wire logic cd_i,
    // transmit side events
    input wire logic tx_done_i,
    input wire logic tx_cts_lost_i,
    input wire logic tx_underrun_i,
    input wire logic tx_irq_req_i,
    // receive buffer side
    input wire logic rx_closed_i,
    input wire logic rx_irq_req_i,
    input wire logic rx_buf_free_i,
    // received characters
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_char_i,
    // outputs
    output bem_rxwr_s rx_wr_o,
    output logic block_end_o,
    output logic irq_o
);

    // registers
    logic [7:0] channel_event_flags;
    logic [7:0] channel_event_enable;
    logic [1:0] mode;
    logic [7:0] sync_char;
    logic [7:0] dle_char;
    bem_entry_s tbl [BEM_TBL_N];
    logic [7:0] acc;
    logic cts_q;
    logic cd_q;
    bem_rx_e rx_state;
    logic dle_pend;
    logic halted;
    logic hunt_after;
    logic [1:0] chk_cnt;

    // ahb data phase capture
    logic dp_wr;
    logic dp_rd;
    logic [7:0] dp_addr;
    logic a_phase;
    logic receive_transparent_enable;
    logic receive_check_include;

    assign a_phase = hsel_i & hready_i & htrans_i[1];
    assign receive_transparent_enable = mode[MODE_TRANSP];
    assign receive_check_include = mode[MODE_CHKINC];

    // address phase register, zero wait states, always okay
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dp_wr <= 1'b0;
            dp_rd <= 1'b0;
            dp_addr <= 8'h00;
        end else begin
            dp_wr <= a_phase & hwrite_i & (hsize_i == HSIZE_WORD);
            dp_rd <= a_phase & ~hwrite_i;
            dp_addr <= haddr_i[7:0];
        end
    end

    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;

    // write decode
    logic wr_event;
    logic wr_enable;
    logic wr_mode;
    logic wr_cmd;
    logic wr_chars;
    logic wr_tbl;
    logic [BEM_TBL_IW-1:0] tbl_idx;
    logic clear_check_accumulation_command;
    logic resync_cmd;

    assign wr_event = dp_wr & (dp_addr == BEM_OFS_EVENT);
    assign wr_enable = dp_wr & (dp_addr == BEM_OFS_ENABLE);
    assign wr_mode = dp_wr & (dp_addr == BEM_OFS_MODE);
    assign wr_cmd = dp_wr & (dp_addr == BEM_OFS_CMD);
    assign wr_chars = dp_wr & (dp_addr == BEM_OFS_CHARS);
    assign wr_tbl = dp_wr & (dp_addr[7:5] == BEM_TBL_PAGE) & (dp_addr[1:0] == 2'h0);
    assign tbl_idx = dp_addr[4:2];
    assign clear_check_accumulation_command = wr_cmd & hwdata_i[CMD_CLRCHK];
    assign resync_cmd = wr_cmd & hwdata_i[CMD_RESYNC];

    // control table match, entries valid up to the first table-end entry
    logic [BEM_TBL_N:0] before_end;
    logic [BEM_TBL_N-1:0] hit;
    assign before_end[0] = 1'b1;
    for (genvar gi = 0; gi < BEM_TBL_N; gi++) begin : g_tbl
        assign before_end[gi+1] = before_end[gi] & ~tbl[gi].last;
        assign hit[gi] = before_end[gi] & ~tbl[gi].last & (tbl[gi].ch == rx_char_i);

        // table entry storage
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                tbl[gi] <= BEM_RST_ENTRY;
            end else if (wr_tbl && tbl_idx == BEM_TBL_IW'(gi)) begin
                tbl[gi] <= bem_entry_s'(hwdata_i[10:0]);
            end
        end
    end

    // first matching entry
    logic any_hit;
    bem_entry_s hit_entry;
    always_comb begin
        any_hit = 1'b0;
        hit_entry = BEM_RST_ENTRY;
        for (int i = BEM_TBL_N - 1; i >= 0; i--) begin
            if (hit[i]) begin
                any_hit = 1'b1;
                hit_entry = tbl[i];
            end
        end
    end

    // receive character classification
    logic active;
    logic is_sync;
    logic is_dle;
    logic do_strip_dle;
    logic do_write;
    logic ctrl_ok;
    logic do_acc;
    logic dropped;
    logic written;
    logic in_check;

    assign active = rx_valid_i & ~halted & (rx_state != RX_HUNT);
    assign is_sync = rx_char_i == sync_char;
    assign is_dle = rx_char_i == dle_char;
    assign in_check = rx_state == RX_CHECK;

    always_comb begin
        do_strip_dle = 1'b0;
        do_write = 1'b0;
        ctrl_ok = 1'b0;
        if (active) begin
            if (in_check) begin
                do_write = 1'b1;
            end else if (receive_transparent_enable && !dle_pend) begin
                do_strip_dle = is_dle;
                do_write = ~is_dle & ~is_sync;
            end else if (receive_transparent_enable) begin
                do_write = ~is_sync; // escaped sync is idle fill
                ctrl_ok = ~is_sync;
            end else begin
                do_write = ~is_sync;
                ctrl_ok = ~is_sync;
            end
        end
    end

    assign written = do_write & rx_buf_free_i;
    assign dropped = do_write & ~rx_buf_free_i;
    // syncs and stripped escapes never reach here, check bytes stay out too
    assign do_acc = written & ~in_check & receive_check_include;

    // receiver state machine
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_state <= RX_HUNT;
            hunt_after <= 1'b0;
            chk_cnt <= 2'h0;
        end else if (resync_cmd || dropped) begin
            rx_state <= RX_HUNT;
        end else begin
            case (rx_state)
                RX_HUNT: begin
                    if (rx_valid_i && !halted && is_sync) begin
                        rx_state <= RX_RECV;
                    end
                end
                RX_RECV: begin
                    if (written && ctrl_ok && any_hit) begin
                        hunt_after <= hit_entry.hunt;
                        if (hit_entry.check) begin
                            rx_state <= RX_CHECK;
                            chk_cnt <= BEM_CHECK_BYTES;
                        end else if (hit_entry.hunt) begin
                            rx_state <= RX_HUNT;
                        end
                    end
                end
                RX_CHECK: begin
                    if (written) begin
                        chk_cnt <= chk_cnt - 2'h1;
                        if (chk_cnt == 2'h1) begin
                            rx_state <= hunt_after ? RX_HUNT : RX_RECV;
                        end
                    end
                end
                default: begin
                    rx_state <= RX_HUNT;
                end
            endcase
        end
    end

    // escape pending and overflow halt
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dle_pend <= 1'b0;
            halted <= 1'b0;
        end else begin
            if (resync_cmd || !receive_transparent_enable) begin
                dle_pend <= 1'b0;
            end else if (active && !in_check) begin
                dle_pend <= do_strip_dle;
            end
            // a drop in the same cycle as a resync still halts
            if (dropped) begin
                halted <= 1'b1;
            end else if (resync_cmd) begin
                halted <= 1'b0;
            end
        end
    end

    // block check accumulation, longitudinal parity
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc <= BEM_RST_ACC;
        end else if (clear_check_accumulation_command) begin
            acc <= BEM_RST_ACC;
        end else if (do_acc) begin
            acc <= acc ^ rx_char_i;
        end
    end

    // buffer write strobe and block end pulse
    logic close_now;
    assign close_now = written & ((ctrl_ok & any_hit & ~hit_entry.check & ~in_check)
                                  | (in_check & (chk_cnt == 2'h1)));
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_wr_o <= '0;
            block_end_o <= 1'b0;
        end else begin
            rx_wr_o.wr <= written;
            rx_wr_o.ctrl <= written & ctrl_ok & any_hit & ~in_check;
            rx_wr_o.chk <= written & in_check;
            rx_wr_o.data <= rx_char_i;
            block_end_o <= close_now;
        end
    end

    // mode, special characters and enable mask
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode <= BEM_RST_MODE;
            sync_char <= BEM_RST_SYNC;
            dle_char <= BEM_RST_DLE;
            channel_event_enable <= BEM_RST_ENABLE;
        end else begin
            if (wr_mode) begin
                mode <= hwdata_i[1:0];
            end
            if (wr_chars) begin
                sync_char <= hwdata_i[7:0];
                dle_char <= hwdata_i[15:8];
            end
            if (wr_enable) begin
                channel_event_enable <= hwdata_i[7:0] & EV_WMASK;
            end
        end
    end

    // event sources
    logic [7:0] ev_set;
    logic [7:0] ev_clr;
    always_comb begin
        ev_set = 8'h00;
        ev_set[EV_CTS] = cts_i ^ cts_q;
        ev_set[EV_CD] = cd_i ^ cd_q;
        ev_set[EV_TXE] = (tx_cts_lost_i | tx_underrun_i) & tx_irq_req_i;
        ev_set[EV_RCH] = written;
        ev_set[EV_NOBUF] = dropped;
        ev_set[EV_TX] = tx_done_i & tx_irq_req_i;
        ev_set[EV_RX] = rx_closed_i & rx_irq_req_i;
    end
    assign ev_clr = wr_event ? hwdata_i[7:0] : 8'h00;
    logic [7:0] next_flags;
    assign next_flags = ((channel_event_flags & ~ev_clr) | ev_set) & EV_WMASK;

    // sticky flags, a new event wins over a same-cycle clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            channel_event_flags <= BEM_RST_EVENT;
            cts_q <= cts_i; // follow the pins so release shows no false change
            cd_q <= cd_i;
        end else begin
            channel_event_flags <= next_flags;
            cts_q <= cts_i;
            cd_q <= cd_i;
        end
    end

    assign irq_o = |(channel_event_flags & channel_event_enable);

    // read mux in data phase, unmapped reads return zero
    logic [31:0] rdata;
    always_comb begin
        rdata = 32'h0000_0000;
        case (dp_addr)
            BEM_OFS_EVENT: rdata[7:0] = channel_event_flags;
            BEM_OFS_ENABLE: rdata[7:0] = channel_event_enable;
            BEM_OFS_MODE: rdata[1:0] = mode;
            BEM_OFS_STATUS: begin
                rdata[ST_CTS] = cts_q;
                rdata[ST_CD] = cd_q;
                rdata[ST_HUNTING] = rx_state == RX_HUNT;
                rdata[ST_DLEPEND] = dle_pend;
                rdata[ST_HALTED] = halted;
                rdata[ST_ACC_LSB +: 8] = acc;
            end
            BEM_OFS_CHARS: rdata[15:0] = {dle_char, sync_char};
            default: begin
                if (dp_addr[7:5] == BEM_TBL_PAGE) begin
                    rdata[10:0] = tbl[dp_addr[4:2]];
                end
            end
        endcase
    end
    assign hrdata_o = dp_rd ? rdata : 32'h0000_0000;

    // checks
    property p_irq_level;
        @(posedge clk_i) disable iff (rst_i)
        (irq_o && !wr_event && !wr_enable) |=> irq_o;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq low with enabled flag");

    property p_w1c;
        @(posedge clk_i) disable iff (rst_i)
        (wr_event && hwdata_i[EV_TX] && !ev_set[EV_TX]) |=> !channel_event_flags[EV_TX];
    endproperty
    a_w1c: assert property (p_w1c) else $error("tx flag not cleared by one");

    property p_zero_keeps;
        @(posedge clk_i) disable iff (rst_i)
        (wr_event && !hwdata_i[EV_RX] && channel_event_flags[EV_RX]) |=> channel_event_flags[EV_RX];
    endproperty
    a_zero_keeps: assert property (p_zero_keeps) else $error("zero write cleared flag");

    property p_cts_change;
        @(posedge clk_i) disable iff (rst_i)
        (cts_i != $past(cts_i)) |=> channel_event_flags[EV_CTS];
    endproperty
    a_cts_change: assert property (p_cts_change) else $error("cts change missed");

    property p_rsvd;
        @(posedge clk_i) disable iff (rst_i)
        !channel_event_flags[EV_RSVD] && !channel_event_enable[EV_RSVD];
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

    property p_rch;
        @(posedge clk_i) disable iff (rst_i)
        rx_wr_o.wr |-> channel_event_flags[EV_RCH];
    endproperty
    a_rch: assert property (p_rch) else $error("char write without flag");

    property p_halt;
        @(posedge clk_i) disable iff (rst_i)
        (dropped && !resync_cmd) |=> (halted && !rx_wr_o.wr) ##1 (halted || $past(resync_cmd));
    endproperty
    a_halt: assert property (p_halt) else $error("reception not halted after drop");

    property p_clrchk;
        @(posedge clk_i) disable iff (rst_i)
        clear_check_accumulation_command |=> acc == BEM_RST_ACC;
    endproperty
    a_clrchk: assert property (p_clrchk) else $error("accumulator not cleared");

    property p_strip;
        @(posedge clk_i) disable iff (rst_i)
        do_strip_dle |=> !rx_wr_o.wr && dle_pend && $stable(acc);
    endproperty
    a_strip: assert property (p_strip) else $error("leading escape not stripped");

    property p_check_close;
        @(posedge clk_i) disable iff (rst_i)
        (rx_state == RX_RECV && rx_wr_o.ctrl == 1'b0 && written && ctrl_ok && any_hit
         && hit_entry.check) |=> !block_end_o;
    endproperty
    a_check_close: assert property (p_check_close) else $error("closed before check");

    c_irq: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
    c_block_end: cover property (@(posedge clk_i) disable iff (rst_i) block_end_o);
    c_check: cover property (@(posedge clk_i) disable iff (rst_i) rx_wr_o.chk);
    c_halt: cover property (@(posedge clk_i) disable iff (rst_i) $rose(halted));

endmodule

// ---- testbench/bem_line_model.sv ----
// partner model: receive line handing characters to the channel
`timescale 1ns/1ps
module bem_line_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // request from the bench
    input wire logic send_i,
    input wire logic [7:0] char_i,
    input wire logic [3:0] gap_i,
    // character toward the channel
    output logic rx_valid_o,
    output logic [7:0] rx_char_o
);
    logic [4:0] wait_cnt;
    logic [7:0] held;

    // one character after gap_i + 1 idle cycles; data churns between characters
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wait_cnt <= 5'h00;
            held <= 8'h00;
            rx_valid_o <= 1'b0;
            rx_char_o <= 8'h5a;
        end else if (wait_cnt == 5'h01) begin
            wait_cnt <= 5'h00;
            rx_valid_o <= 1'b1;
            rx_char_o <= held;
        end else begin
            rx_valid_o <= 1'b0;
            rx_char_o <= ~rx_char_o;
            if (wait_cnt != 5'h00) begin
                wait_cnt <= wait_cnt - 5'h01;
            end else if (send_i) begin
                held <= char_i;
                wait_cnt <= {1'b0, gap_i} + 5'h01;
            end
        end
    end
endmodule

// ---- testbench/bem_channel_bench.sv ----
// testbench: register, event, interrupt and receive checks of the channel
`timescale 1ns/1ps
module bem_channel_bench
    import bem_pkg::*;
;
    logic clk_i, rst_i, hsel, hwrite, cts, cd, gate, buf_free, snd;
    logic hreadyout, hresp, rx_valid, block_end, irq;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [7:0] rx_char, chr;
    logic [3:0] pl, gap;
    bem_rxwr_s rx_wr, last_wr;
    int bad_count, samples_checked, wr_n, be_n, cycles;
    localparam logic [5:0] STIM [7] = '{6'h10, 6'h20, 6'h02, 6'h04, 6'h01, 6'h08, 6'h09};
    localparam logic [7:0] EXPF [7] = '{8'h80, 8'h40, 8'h10, 8'h10, 8'h02, 8'h01, 8'h00};

    bem_channel i_dut (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(HSIZE_WORD), .hwdata_i(hwdata),
        .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
        .cts_i(cts), .cd_i(cd), .tx_done_i(pl[0]), .tx_cts_lost_i(pl[1]),
        .tx_underrun_i(pl[2]), .tx_irq_req_i(gate), .rx_closed_i(pl[3]), .rx_irq_req_i(gate),
        .rx_buf_free_i(buf_free), .rx_valid_i(rx_valid), .rx_char_i(rx_char),
        .rx_wr_o(rx_wr), .block_end_o(block_end), .irq_o(irq));
    bem_line_model i_line (.clk_i(clk_i), .rst_i(rst_i), .send_i(snd), .char_i(chr),
        .gap_i(gap), .rx_valid_o(rx_valid), .rx_char_o(rx_char));

    // clock
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // buffer write monitor and hang limit
    always @(posedge clk_i) begin
        cycles++;
        if (rx_wr.wr === 1'b1) begin
            wr_n++;
            last_wr = rx_wr;
        end
        if (block_end === 1'b1) be_n++;
        if (cycles == 5000) begin
            bad_count++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one ahb-lite single transfer, read data kept in rd
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= wr;
        @(posedge clk_i);
        while (hreadyout !== 1'b1) @(posedge clk_i);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk_i);
        while (hreadyout !== 1'b1) @(posedge clk_i);
        rd = hrdata;
        #1;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    task automatic rx(input logic [7:0] c, input logic [3:0] g);
        @(posedge clk_i);
        snd <= 1'b1;
        chr <= c;
        gap <= g;
        @(posedge clk_i);
        snd <= 1'b0;
        repeat (g + 4) @(posedge clk_i);
        #1;
    endtask

    task automatic evt(input logic [5:0] s, input logic g);
        @(posedge clk_i);
        pl <= s[3:0];
        gate <= g;
        if (s[4]) cts <= ~cts;
        if (s[5]) cd <= ~cd;
        @(posedge clk_i);
        pl <= 4'h0;
        #1;
    endtask

    // main sequence
    initial begin
        {rst_i, hsel, hwrite, cts, cd, gate, buf_free, snd} = 8'h82;
        {htrans, haddr, hwdata, chr, pl, gap} = '0;
        {bad_count, samples_checked, wr_n, be_n, cycles} = '0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(BEM_OFS_EVENT, 32'h0); // reset
        rd_chk(BEM_OFS_ENABLE, 32'h0); // reset
        rd_chk(8'h18, 32'h0);
        check(hresp, 1'b0);
        bus(1'b1, BEM_OFS_ENABLE, 32'hff);
        rd_chk(BEM_OFS_ENABLE, 32'hdf); // read-write
        bus(1'b1, BEM_OFS_ENABLE, 32'h0);
        for (int i = 0; i < 7; i++) begin
            bus(1'b1, BEM_OFS_EVENT, 32'hff);
            evt(STIM[i], i < 6);
            rd_chk(BEM_OFS_EVENT, {24'h0, EXPF[i]});
        end
        // masked request and write-one clearing
        bus(1'b1, BEM_OFS_EVENT, 32'hff);
        bus(1'b1, BEM_OFS_ENABLE, 32'h81);
        evt(6'h19, 1'b1);
        check(irq, 1'b1);
        bus(1'b1, BEM_OFS_EVENT, 32'h80);
        check(irq, 1'b1);
        rd_chk(BEM_OFS_EVENT, 32'h03);
        bus(1'b1, BEM_OFS_EVENT, 32'h01);
        check(irq, 1'b0);
        bus(1'b1, BEM_OFS_ENABLE, 32'h02);
        check(irq, 1'b1);
        bus(1'b1, BEM_OFS_EVENT, 32'hff);
        check(irq, 1'b0);
        // receive: enable char interrupt, program table
        bus(1'b1, BEM_OFS_ENABLE, 32'h08);
        bus(1'b1, 8'h20, 32'h02d);
        bus(1'b1, 8'h24, 32'h603);
        bus(1'b1, 8'h28, 32'h100);
        rx(8'h41, 4'h0);
        check(wr_n, 0);
        rd_chk(BEM_OFS_STATUS, {27'h0, 3'h1, cd, cts});
        rx(8'h32, 4'h0);
        rx(8'h41, 4'h3);
        check(last_wr, {3'b100, 8'h41});
        check(irq, 1'b1);
        rd_chk(BEM_OFS_EVENT, 32'h08);
        rx(8'h32, 4'h0);
        rx(8'h42, 4'h0);
        check(wr_n, 2);
        bus(1'b0, BEM_OFS_STATUS, 32'h0);
        check(rd[15:8], 8'h03);
        bus(1'b1, BEM_OFS_CMD, 32'h1);
        bus(1'b0, BEM_OFS_STATUS, 32'h0);
        check(rd[15:8], 8'h00);
        bus(1'b1, BEM_OFS_ENABLE, 32'h0);
        rx(8'h2d, 4'h0);
        check(be_n, 1);
        check(last_wr, {3'b110, 8'h2d});
        rx(8'h03, 4'h0);
        rx(8'h11, 4'h0);
        check(be_n, 1);
        rx(8'h22, 4'h0);
        check(be_n, 2);
        check(last_wr, {3'b101, 8'h22});
        bus(1'b0, BEM_OFS_STATUS, 32'h0);
        check(rd[2], 1'b1);
        // transparent reception
        rx(8'h32, 4'h0);
        bus(1'b1, BEM_OFS_MODE, 32'h3);
        rx(8'h2d, 4'h0);
        check(be_n, 2);
        rx(8'h10, 4'h2);
        rx(8'h2d, 4'h0);
        check(be_n, 3);
        check(wr_n, 8);
        check(last_wr, {3'b110, 8'h2d});
        bus(1'b1, BEM_OFS_MODE, 32'h2);
        // no free buffer halts until resync
        @(posedge clk_i);
        buf_free <= 1'b0;
        rx(8'h55, 4'h3);
        check(wr_n, 8);
        rd_chk(BEM_OFS_EVENT, 32'h0c);
        @(posedge clk_i);
        buf_free <= 1'b1;
        rx(8'h56, 4'h0);
        check(wr_n, 8);
        bus(1'b1, BEM_OFS_CMD, 32'h2);
        rx(8'h32, 4'h0);
        rx(8'h57, 4'h0);
        check(last_wr, {3'b100, 8'h57});
        // check inclusion off keeps the accumulator still
        bus(1'b1, BEM_OFS_MODE, 32'h0);
        bus(1'b1, BEM_OFS_CMD, 32'h1);
        rx(8'h58, 4'h0);
        check(last_wr, {3'b100, 8'h58});
        bus(1'b0, BEM_OFS_STATUS, 32'h0);
        check(rd[15:8], 8'h00);
        // second reset in mid-run
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(BEM_OFS_EVENT, 32'h0);
        rd_chk(BEM_OFS_ENABLE, 32'h0);
        close_out();
    end
endmodule
